// *** core/irc_carrier_gen.sv ***
// Infrared carrier generator with timer gating of the remote output pin
// Notes on behaviour
// RQ1: Carrier made by one 9-bit counter and low and high width registers.
// RQ2: Bit 9 of the low width register always reads and stays zero.
// RQ3: Carrier counter ticks at twice the system clock frequency.
// RQ4: Each phase lasts register value plus one carrier counter ticks.
// RQ5: At 4 MHz system clock, each width spans 250 ns to 64 us.
// RQ6: Software writes only 001H through 1FFH into both width registers.
// RQ7: Widths read and written by nibble, full 10-bit load, or pointer load. The code has no pointer load.
// RQ8: Carrier reaches the pin only while the disable bit is zero.
// RQ9: Software sets widths before starting the timer, not during carrier output.
// RQ10: Software changes widths only while the remote output is low.
// RQ11: A timer start makes the carrier begin with its low phase.
// RQ12: Counter reaching zero stops the carrier and holds the pin low.
// RQ13: Zero reached in a high phase still completes that whole high phase.
// RQ14: Pin low if counter or enable zero, else carrier or steady high. With enable set, the code keeps the pin high until a begun high phase ends.
// RQ15: Active interval is loaded count plus one times 64 fx, minus 4 fx.
// RQ16: Software enable toggling gives pulses as short as 64 minus 4 fx.
// RQ17: In halt mode the timer and both outputs keep running.
// RQ18: In stop mode the timer halts, clears, and oscillator pins go low.
// RQ19: Loading a nonzero value into the down counter starts the timer.
// RQ20: Down counter drops by one each 64 fx; end signal while zero.
// RQ21: With enable set, indicator low while running and high when stopped.
// RQ22: Carrier counter held cleared whenever the pin is forced low or high. The code lets a begun high phase count down to zero first.
// RQ23: At each phase end the counter reloads and switches phase at once.
`default_nettype none
module irc_carrier_gen (
  // Clock, reset and freeze
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  // Width register access
  input wire logic i_mod_sel,
  input wire logic i_mod_nib_wr,
  input wire logic i_mod_nib_rd,
  input wire logic [1:0] i_nib_idx,
  input wire logic [irc_pkg::NIB_W-1:0] i_nib_wdata,
  input wire logic i_mod_wr,
  input wire logic [irc_pkg::REG_W-1:0] i_mod_wdata,
  output logic [irc_pkg::NIB_W-1:0] o_nib_rdata_q,
  output logic o_nib_rvalid_q,
  // Timer load
  input wire logic i_tmr_wr,
  input wire logic [irc_pkg::REG_W-1:0] i_tmr_wdata,
  // Standby
  input wire logic i_halt,
  input wire logic i_stop,
  output logic o_osc_hold_low_q,
  // Pins and status
  output logic o_ir_output_pin_q,
  output logic o_sense_indicator_pin_q,
  output logic o_tmr_end_q
);
  logic [irc_pkg::REG_W-1:0] low_width_modulo_q;
  logic [irc_pkg::REG_W-1:0] high_width_modulo_q;
  logic [irc_pkg::CAR_W-1:0] down_counter_bits_q;
  logic timer_output_enable_q;
  logic [irc_pkg::PRE_W-1:0] pre_q;
  logic running;
  logic carrier_disable_bit;
  logic ir_d;
  logic [irc_pkg::NIB_W-1:0] rd_mux;
  logic [irc_pkg::REG_W-1:0] rd_reg;

  irc_car_if car ();

  assign running = (down_counter_bits_q != '0);
  assign carrier_disable_bit = high_width_modulo_q[irc_pkg::DIS_BIT];

  // Width registers; software keeps values in range and quiet while the pin toggles
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      low_width_modulo_q <= irc_pkg::LOW_W_RST;
      high_width_modulo_q <= irc_pkg::HIGH_W_RST;
    end else if (i_clk_en) begin
      if (i_mod_wr) begin
        if (i_mod_sel == irc_pkg::SEL_HIGH) begin
          high_width_modulo_q <= i_mod_wdata; // see RQ7
        end else begin
          low_width_modulo_q <= {1'b0, i_mod_wdata[irc_pkg::CAR_W-1:0]}; // see RQ2
        end
      end else if (i_mod_nib_wr) begin
        if (i_mod_sel == irc_pkg::SEL_HIGH) begin
          case (i_nib_idx)
            irc_pkg::NIB_LO: high_width_modulo_q[3:0] <= i_nib_wdata; // see RQ7
            irc_pkg::NIB_MID: high_width_modulo_q[7:4] <= i_nib_wdata;
            irc_pkg::NIB_HI: high_width_modulo_q[9:8] <= i_nib_wdata[irc_pkg::NIB_TOP_W-1:0];
            default: high_width_modulo_q <= high_width_modulo_q;
          endcase
        end else begin
          case (i_nib_idx)
            irc_pkg::NIB_LO: low_width_modulo_q[3:0] <= i_nib_wdata; // see RQ7
            irc_pkg::NIB_MID: low_width_modulo_q[7:4] <= i_nib_wdata;
            irc_pkg::NIB_HI: low_width_modulo_q[9:8] <= {1'b0, i_nib_wdata[0]}; // see RQ2
            default: low_width_modulo_q <= low_width_modulo_q;
          endcase
        end
      end
    end
  end

  // Nibble read back, the upper nibble holds only bits 9 and 8
  always_comb begin
    rd_reg = (i_mod_sel == irc_pkg::SEL_HIGH) ? high_width_modulo_q : low_width_modulo_q;
    case (i_nib_idx)
      irc_pkg::NIB_LO: rd_mux = rd_reg[3:0];
      irc_pkg::NIB_MID: rd_mux = rd_reg[7:4];
      irc_pkg::NIB_HI: rd_mux = {2'h0, rd_reg[9:8]};
      default: rd_mux = 4'h0;
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_nib_rdata_q <= 4'h0;
      o_nib_rvalid_q <= 1'b0;
    end else if (i_clk_en) begin
      o_nib_rvalid_q <= i_mod_nib_rd; // see RQ7
      if (i_mod_nib_rd) begin
        o_nib_rdata_q <= rd_mux;
      end
    end
  end

  // Timer: halt mode needs no term here, only stop touches the count
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      down_counter_bits_q <= irc_pkg::TMR_RST[irc_pkg::CAR_W-1:0];
      timer_output_enable_q <= irc_pkg::TMR_RST[irc_pkg::EN_BIT];
      pre_q <= '0;
    end else if (i_clk_en) begin
      if (i_stop) begin
        down_counter_bits_q <= '0; // see RQ18
        timer_output_enable_q <= 1'b0;
        pre_q <= '0;
      end else if (i_tmr_wr) begin
        // Enable toggled by software gives its own short pulses on the pin
        timer_output_enable_q <= i_tmr_wdata[irc_pkg::EN_BIT]; // see RQ16
        down_counter_bits_q <= i_tmr_wdata[irc_pkg::CAR_W-1:0]; // see RQ19
        // The first decrement comes two steps less the trim, later steps are full length
        pre_q <= irc_pkg::PRE_FIRST; // see RQ15
      end else if (running) begin
        if (pre_q == '0) begin
          down_counter_bits_q <= down_counter_bits_q - 1'b1; // see RQ20
          pre_q <= irc_pkg::PRE_STEP; // see RQ20
        end else begin
          pre_q <= pre_q - 1'b1; // see RQ17
        end
      end
    end
  end

  // Carrier gate
  assign car.run = timer_output_enable_q && !carrier_disable_bit && running; // see RQ8
  assign car.low_w = low_width_modulo_q[irc_pkg::CAR_W-1:0]; // see RQ1 RQ5
  assign car.high_w = high_width_modulo_q[irc_pkg::CAR_W-1:0];

  // Carrier level already stays high across a finishing high phase
  assign ir_d = timer_output_enable_q && ((running && carrier_disable_bit) || car.level); // see RQ14

  irc_carrier_seq u_seq (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_clk_en(i_clk_en),
    .car(car)
  );

  // Output registers; the carrier counter steps once per clock, which is 2x fx
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ir_output_pin_q <= 1'b0;
      o_sense_indicator_pin_q <= 1'b1;
      o_tmr_end_q <= 1'b1;
      o_osc_hold_low_q <= 1'b0;
    end else if (i_clk_en) begin
      o_ir_output_pin_q <= ir_d; // see RQ3
      o_sense_indicator_pin_q <= !(timer_output_enable_q && running); // see RQ21
      o_tmr_end_q <= !running; // see RQ20
      o_osc_hold_low_q <= i_stop; // see RQ18
    end
  end

  // Helper logic for the interval check
  logic [15:0] act_cnt_q;
  logic [15:0] exp_cnt_q;
  logic clean_q;
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      act_cnt_q <= 16'h0000;
      exp_cnt_q <= 16'h0000;
      clean_q <= 1'b0;
    end else if (i_clk_en) begin
      if (i_stop) begin
        clean_q <= 1'b0;
      end else if (i_tmr_wr) begin
        act_cnt_q <= 16'h0000;
        exp_cnt_q <= 16'((32'(i_tmr_wdata[irc_pkg::CAR_W-1:0]) + 32'd1) * irc_pkg::TMR_STEP_CYC
                     - irc_pkg::TMR_TRIM_CYC);
        clean_q <= (i_tmr_wdata[irc_pkg::CAR_W-1:0] != '0);
      end else if (running) begin
        act_cnt_q <= act_cnt_q + 16'h0001;
      end
    end
  end

  property p_interval;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (clean_q && $fell(running)) |-> (act_cnt_q == exp_cnt_q);
  endproperty
  a_interval: assert property (p_interval) else $error("timer interval length wrong"); // see RQ15

  property p_low_bit9;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_clk_en && (i_mod_wr || i_mod_nib_wr) && i_mod_sel == irc_pkg::SEL_LOW)
      |=> (low_width_modulo_q[irc_pkg::DIS_BIT] == 1'b0);
  endproperty
  a_low_bit9: assert property (p_low_bit9) else $error("low width bit 9 set"); // see RQ2

  property p_off_low;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_clk_en && !timer_output_enable_q) |=> !o_ir_output_pin_q;
  endproperty
  a_off_low: assert property (p_off_low) else $error("pin high with enable clear"); // see RQ14

  property p_steady_high;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_clk_en && timer_output_enable_q && carrier_disable_bit && running) |=> o_ir_output_pin_q;
  endproperty
  a_steady_high: assert property (p_steady_high) else $error("pin not steady high"); // see RQ8

  property p_stop_low;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_clk_en && !running && !car.level) |=> !o_ir_output_pin_q;
  endproperty
  a_stop_low: assert property (p_stop_low) else $error("pin high after timer end"); // see RQ12

  property p_indicator;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_clk_en && timer_output_enable_q) |=> (o_sense_indicator_pin_q == !$past(running));
  endproperty
  a_indicator: assert property (p_indicator) else $error("indicator level wrong"); // see RQ21

  property p_stop_clear;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_clk_en && i_stop) |=> (down_counter_bits_q == '0 && !timer_output_enable_q);
  endproperty
  a_stop_clear: assert property (p_stop_clear) else $error("stop did not clear timer"); // see RQ18

  property p_start;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_clk_en && i_tmr_wr && !i_stop && i_tmr_wdata[irc_pkg::CAR_W-1:0] != '0)
      |=> running ##1 !o_tmr_end_q;
  endproperty
  a_start: assert property (p_start) else $error("timer failed to start"); // see RQ19

  property p_step;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_clk_en && running && pre_q == '0 && !i_tmr_wr && !i_stop)
      |=> (down_counter_bits_q == $past(down_counter_bits_q) - 1'b1 && pre_q == irc_pkg::PRE_STEP);
  endproperty
  a_step: assert property (p_step) else $error("down counter step wrong"); // see RQ20

  property p_halt_runs;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_clk_en && i_halt && !i_stop && !i_tmr_wr && running && pre_q != '0)
      |=> (pre_q == $past(pre_q) - 1'b1);
  endproperty
  a_halt_runs: assert property (p_halt_runs) else $error("timer stalled in halt"); // see RQ17

  // A low phase cut by the gate must not linger, or the pin could pulse once more
  property p_low_cut;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_clk_en && car.busy && !car.level && !car.run) |=> !car.busy;
  endproperty
  a_low_cut: assert property (p_low_cut) else $error("low phase not cut"); // see RQ12

  property p_load;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_clk_en && i_tmr_wr && !i_stop)
      |=> (pre_q == irc_pkg::PRE_FIRST
           && down_counter_bits_q == $past(i_tmr_wdata[irc_pkg::CAR_W-1:0]));
  endproperty
  a_load: assert property (p_load) else $error("timer load wrong"); // see RQ15 RQ19

  property p_zero_hold;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_clk_en && !running && !i_tmr_wr) |=> (!running && o_tmr_end_q);
  endproperty
  a_zero_hold: assert property (p_zero_hold) else $error("timer left zero"); // see RQ20

  property p_carrier_pin;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_clk_en && timer_output_enable_q && running && !carrier_disable_bit)
      |=> (o_ir_output_pin_q == $past(car.level));
  endproperty
  a_carrier_pin: assert property (p_carrier_pin) else $error("pin off carrier"); // see RQ14

  property p_rvalid_pulse;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_clk_en && !i_mod_nib_rd) |=> !o_nib_rvalid_q;
  endproperty
  a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("read valid held"); // see RQ7
endmodule : irc_carrier_gen
`default_nettype wire

// *** inc/irc_pkg.sv ***
// Shared constants and types for the infrared carrier generator
`default_nettype none
package irc_pkg;
  // Widths
  localparam int unsigned CAR_W = 9;
  localparam int unsigned REG_W = 10;
  localparam int unsigned NIB_W = 4;
  localparam int unsigned PRE_W = 8;
  // Field positions
  localparam int unsigned DIS_BIT = 9;
  localparam int unsigned EN_BIT = 9;
  localparam int unsigned NIB_TOP_W = 2;
  // Nibble selectors for the 4-bit transfers
  localparam logic [1:0] NIB_LO = 2'h0;
  localparam logic [1:0] NIB_MID = 2'h1;
  localparam logic [1:0] NIB_HI = 2'h2;
  // Register selectors
  localparam logic SEL_LOW = 1'h0;
  localparam logic SEL_HIGH = 1'h1;
  // Reset values
  localparam logic [REG_W-1:0] LOW_W_RST = 10'h001;
  localparam logic [REG_W-1:0] HIGH_W_RST = 10'h001;
  localparam logic [REG_W-1:0] TMR_RST = 10'h000;
  // Clocking: the carrier counter runs at twice the system clock frequency,
  // so i_clk_sys is that doubled clock and fx is half of it
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned CAR_MULT = 2;
  localparam int unsigned FX_HZ = CLK_HZ / CAR_MULT;
  // Timer step and trim, in periods of the system clock frequency
  localparam int unsigned TMR_STEP_FX = 64;
  localparam int unsigned TMR_TRIM_FX = 4;
  localparam int unsigned TMR_STEP_CYC = TMR_STEP_FX * CLK_HZ / FX_HZ;
  localparam int unsigned TMR_TRIM_CYC = TMR_TRIM_FX * CLK_HZ / FX_HZ;
  // First decrement comes two steps less the trim
  localparam logic [PRE_W-1:0] PRE_STEP = PRE_W'(TMR_STEP_CYC - 1);
  localparam logic [PRE_W-1:0] PRE_FIRST = PRE_W'(2 * TMR_STEP_CYC - TMR_TRIM_CYC - 1);
  // Carrier sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_LOW = 3'b010,
    ST_HIGH = 3'b100
  } irc_state_t;
endpackage : irc_pkg
`default_nettype wire

// *** inc/irc_car_if.sv ***
// Link between the gating logic and the carrier sequencer
`default_nettype none
interface irc_car_if;
  logic run;
  logic [irc_pkg::CAR_W-1:0] low_w;
  logic [irc_pkg::CAR_W-1:0] high_w;
  logic level;
  logic busy;
  modport ctrl (output run, output low_w, output high_w, input level, input busy);
  modport seq (input run, input low_w, input high_w, output level, output busy);
endinterface : irc_car_if
`default_nettype wire

// *** core/irc_carrier_seq.sv ***
// Carrier sequencer: 9-bit counter alternating low and high phase widths
`default_nettype none
module irc_carrier_seq (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  // Link to gating logic
  irc_car_if.seq car
);
  irc_pkg::irc_state_t state_q;
  logic [irc_pkg::CAR_W-1:0] cnt_q;

  assign car.level = (state_q == irc_pkg::ST_HIGH);
  assign car.busy = (state_q != irc_pkg::ST_IDLE);

  // A high phase that has begun always runs to its end, so a pulse on the pin is cut only when the enable bit clears
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= irc_pkg::ST_IDLE;
      cnt_q <= '0;
    end else if (i_clk_en) begin
      case (state_q)
        irc_pkg::ST_IDLE: begin
          cnt_q <= '0; // see RQ22
          if (car.run) begin
            state_q <= irc_pkg::ST_LOW; // see RQ11
            cnt_q <= car.low_w; // see RQ4
          end
        end
        irc_pkg::ST_LOW: begin
          if (!car.run) begin
            state_q <= irc_pkg::ST_IDLE; // see RQ12
            cnt_q <= '0; // see RQ22
          end else if (cnt_q == '0) begin
            state_q <= irc_pkg::ST_HIGH; // see RQ23
            cnt_q <= car.high_w; // see RQ4
          end else begin
            cnt_q <= cnt_q - 1'b1; // see RQ1
          end
        end
        irc_pkg::ST_HIGH: begin
          if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1; // see RQ13
          end else if (car.run) begin
            state_q <= irc_pkg::ST_LOW; // see RQ23
            cnt_q <= car.low_w;
          end else begin
            state_q <= irc_pkg::ST_IDLE; // see RQ13
            cnt_q <= '0;
          end
        end
        default: begin
          state_q <= irc_pkg::ST_IDLE;
          cnt_q <= '0;
        end
      endcase
    end
  end

  property p_start_low;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_clk_en && state_q == irc_pkg::ST_IDLE && car.run)
      |=> (state_q == irc_pkg::ST_LOW && cnt_q == $past(car.low_w));
  endproperty
  a_start_low: assert property (p_start_low) else $error("carrier did not start low"); // see RQ11

  property p_low_to_high;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_clk_en && state_q == irc_pkg::ST_LOW && cnt_q == '0 && car.run)
      |=> (state_q == irc_pkg::ST_HIGH && cnt_q == $past(car.high_w));
  endproperty
  a_low_to_high: assert property (p_low_to_high) else $error("low phase did not hand over"); // see RQ23

  property p_high_complete;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_clk_en && state_q == irc_pkg::ST_HIGH && cnt_q != '0)
      |=> (state_q == irc_pkg::ST_HIGH);
  endproperty
  a_high_complete: assert property (p_high_complete) else $error("high phase cut short"); // see RQ13

  property p_idle_clear;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (state_q == irc_pkg::ST_IDLE && $past(state_q) == irc_pkg::ST_IDLE) |-> (cnt_q == '0);
  endproperty
  a_idle_clear: assert property (p_idle_clear) else $error("idle counter not cleared"); // see RQ22
endmodule : irc_carrier_seq
`default_nettype wire

// *** tb/irc_led_model.sv ***
// Infrared LED drive model that measures run lengths on the remote pin
`default_nettype none
module irc_led_model (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Pin and measurement clear
  input wire logic i_ir_output_pin,
  input wire logic i_clr,
  // Run length extremes, in clocks
  output logic [15:0] o_hi_min,
  output logic [15:0] o_hi_max,
  output logic [15:0] o_lo_min,
  output logic [15:0] o_lo_max
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] run;
  logic prev;
  logic seen_hi;
  // Low runs only count between two highs, so idle time is never mistaken for a phase
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n || i_clr) begin
      run <= 16'h0000;
      prev <= 1'b0;
      seen_hi <= 1'b0;
      o_hi_min <= 16'hFFFF;
      o_hi_max <= 16'h0000;
      o_lo_min <= 16'hFFFF;
      o_lo_max <= 16'h0000;
    end else begin
      prev <= i_ir_output_pin;
      if (i_ir_output_pin === prev) begin
        run <= run + 16'h0001;
      end else begin
        run <= 16'h0001;
        if (prev) begin
          seen_hi <= 1'b1;
          if (run < o_hi_min) o_hi_min <= run;
          if (run > o_hi_max) o_hi_max <= run;
        end else if (seen_hi) begin
          if (run < o_lo_min) o_lo_min <= run;
          if (run > o_lo_max) o_lo_max <= run;
        end
      end
    end
  end
endmodule : irc_led_model
`default_nettype wire

// *** tb/tb_ir_carrier_generator.sv ***
// Self-checking bench for the infrared carrier generator
`default_nettype none
module tb_ir_carrier_generator;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic mod_sel = 1'b0, nib_wr = 1'b0, nib_rd = 1'b0, mod_wr = 1'b0;
  logic tmr_wr = 1'b0, stop = 1'b0, halt = 1'b0, clr = 1'b0;
  logic [1:0] nib_idx = 2'h0;
  logic [3:0] nib_wdata = 4'h0;
  logic [9:0] mod_wdata = 10'h000, tmr_wdata = 10'h000;
  logic [3:0] rdata;
  logic rvalid, osc, pin, ind, tend;
  logic [15:0] hmin, hmax, lmin, lmax;
  int error_cnt = 0;
  int samples_checked = 0;
  int seed = 32'h735bd463;
  int k, act, phi, bad;
  logic [9:0] v, hv;
  logic [8:0] lw, hw, n;
  logic [3:0] nb;

  always #10 clk_sys = ~clk_sys;

  irc_carrier_gen i_dut (
    .i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_clk_en(1'b1),
    .i_mod_sel(mod_sel), .i_mod_nib_wr(nib_wr), .i_mod_nib_rd(nib_rd),
    .i_nib_idx(nib_idx), .i_nib_wdata(nib_wdata), .i_mod_wr(mod_wr),
    .i_mod_wdata(mod_wdata), .o_nib_rdata_q(rdata), .o_nib_rvalid_q(rvalid),
    .i_tmr_wr(tmr_wr), .i_tmr_wdata(tmr_wdata), .i_halt(halt), .i_stop(stop),
    .o_osc_hold_low_q(osc), .o_ir_output_pin_q(pin),
    .o_sense_indicator_pin_q(ind), .o_tmr_end_q(tend)
  );

  irc_led_model i_led (
    .i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_ir_output_pin(pin), .i_clr(clr),
    .o_hi_min(hmin), .o_hi_max(hmax), .o_lo_min(lmin), .o_lo_max(lmax)
  );

  function automatic int exp_act(input logic [8:0] cnt);
    return (int'(cnt) + 1) * irc_pkg::TMR_STEP_CYC - irc_pkg::TMR_TRIM_CYC;
  endfunction : exp_act

  function automatic logic [9:0] exp_rd(input logic sel, input logic [9:0] d);
    return sel ? d : {1'b0, d[8:0]};
  endfunction : exp_rd

  function automatic logic [8:0] rnd_w();
    logic [8:0] r;
    r = 9'($random(seed)) & 9'h01F;
    return (r == 9'h000) ? 9'h001 : r;
  endfunction : rnd_w

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_flag(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected flag at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_flag

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic wr_full(input logic sel, input logic [9:0] d);
    @(negedge clk_sys);
    mod_sel = sel;
    mod_wdata = d;
    mod_wr = 1'b1;
    @(negedge clk_sys);
    mod_wr = 1'b0;
  endtask : wr_full

  task automatic wr_nib(input logic sel, input logic [1:0] idx, input logic [3:0] d);
    @(negedge clk_sys);
    mod_sel = sel;
    nib_idx = idx;
    nib_wdata = d;
    nib_wr = 1'b1;
    @(negedge clk_sys);
    nib_wr = 1'b0;
  endtask : wr_nib

  task automatic rd_nib(input logic sel, input logic [1:0] idx, output logic [3:0] d);
    @(negedge clk_sys);
    mod_sel = sel;
    nib_idx = idx;
    nib_rd = 1'b1;
    @(negedge clk_sys);
    nib_rd = 1'b0;
    chk_flag(rvalid, 1'b1);
    d = rdata;
  endtask : rd_nib

  task automatic rd_reg(input logic sel, output logic [9:0] d);
    logic [3:0] a, b, c;
    rd_nib(sel, irc_pkg::NIB_LO, a);
    rd_nib(sel, irc_pkg::NIB_MID, b);
    rd_nib(sel, irc_pkg::NIB_HI, c);
    d = {c[1:0], b, a};
  endtask : rd_reg

  // Counts active clocks, pin-high clocks and wrong indicator clocks of one run
  task automatic run_tmr(input logic en, input logic [8:0] cnt, output int a,
                         output int p, output int b);
    int i;
    a = 0;
    p = 0;
    b = 0;
    @(negedge clk_sys);
    tmr_wdata = {en, cnt};
    tmr_wr = 1'b1;
    @(negedge clk_sys);
    tmr_wr = 1'b0;
    for (i = 0; i < 4000; i++) begin
      @(negedge clk_sys);
      if (tend === 1'b0) begin
        a++;
        if (pin === 1'b1) p++;
        if (ind !== ~en) b++;
      end else if (a > 0) begin
        break;
      end
    end
    // A long high phase may still be finishing after the timer has ended
    repeat (600) @(negedge clk_sys);
  endtask : run_tmr

  initial begin
    #400_000;
    error_cnt++;
    report_and_stop();
  end

  initial begin
    repeat (10) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_n = 1'b1;
    chk_flag(tend, 1'b1);
    chk_flag(ind, 1'b1);
    chk_flag(pin, 1'b0);
    rd_reg(irc_pkg::SEL_LOW, v);
    chk_val(16'(v), 16'(irc_pkg::LOW_W_RST));
    rd_reg(irc_pkg::SEL_HIGH, v);
    chk_val(16'(v), 16'(irc_pkg::HIGH_W_RST));
    rd_nib(irc_pkg::SEL_HIGH, 2'h3, nb);
    chk_val(16'(nb), 16'h0000);
    $display("Test reset and register defaults done");
    for (k = 0; k < 5; k++) begin
      lw = (k == 0) ? 9'h001 : rnd_w();
      hw = (k == 0) ? 9'h001 : (k == 1) ? 9'h1FF : rnd_w();
      n = (k == 0) ? 9'h001 : (k == 1) ? 9'h004 : 9'($random(seed) & 32'h1) + 9'h001;
      hv = {(k == 4), hw};
      wr_full(irc_pkg::SEL_LOW, {1'b1, lw});
      rd_reg(irc_pkg::SEL_LOW, v);
      chk_val(16'(v), 16'(exp_rd(1'b0, {1'b1, lw})));
      wr_nib(irc_pkg::SEL_HIGH, irc_pkg::NIB_LO, hv[3:0]);
      wr_nib(irc_pkg::SEL_HIGH, irc_pkg::NIB_MID, hv[7:4]);
      wr_nib(irc_pkg::SEL_HIGH, irc_pkg::NIB_HI, {2'h0, hv[9:8]});
      rd_reg(irc_pkg::SEL_HIGH, v);
      chk_val(16'(v), 16'(exp_rd(1'b1, hv)));
      halt = k[0];
      @(negedge clk_sys);
      clr = 1'b1;
      @(negedge clk_sys);
      clr = 1'b0;
      run_tmr(1'b1, n, act, phi, bad);
      chk_val(16'(act), 16'(exp_act(n)));
      chk_val(16'(bad), 16'h0000);
      if (k == 4) begin
        chk_val(16'(phi), 16'(act));
      end else begin
        chk_val(hmin, 16'(hw) + 16'h0001);
        chk_val(hmax, 16'(hw) + 16'h0001);
        chk_val(lmin, 16'(lw) + 16'h0001);
        chk_val(lmax, 16'(lw) + 16'h0001);
      end
      $display("Test carrier run %0d done", k);
    end
    halt = 1'b0;
    run_tmr(1'b0, 9'h001, act, phi, bad);
    chk_val(16'(phi), 16'h0000);
    chk_val(16'(bad), 16'h0000);
    $display("Test output disabled done");
    @(negedge clk_sys);
    tmr_wdata = {1'b1, 9'h005};
    tmr_wr = 1'b1;
    @(negedge clk_sys);
    tmr_wr = 1'b0;
    repeat (20) @(negedge clk_sys);
    chk_flag(tend, 1'b0);
    stop = 1'b1;
    repeat (2) @(negedge clk_sys);
    chk_flag(tend, 1'b1);
    chk_flag(osc, 1'b1);
    chk_flag(pin, 1'b0);
    stop = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk_flag(osc, 1'b0);
    $display("Test stop mode done");
    report_and_stop();
  end
endmodule : tb_ir_carrier_generator
`default_nettype wire
